// [spi_host_pkg.sv]
// constants shared by the serial host port and its timer
package spi_host_pkg;
    // system clock
    localparam int CLK_PERIOD_NS = 20;
    // half period of the generated serial clock, 6 system clocks, kept well above the device's 48 ns pulses
    localparam int SCK_HALF_NS = 120;
    localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // idle time after a write, normal mode
    localparam int IDLE_NORMAL_NS = 2000;
    localparam int IDLE_NORMAL_CYCLES = (IDLE_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // idle time after a write, suspend mode
    localparam int IDLE_SUSPEND_US = 450;
    localparam int IDLE_SUSPEND_CYCLES = (IDLE_SUSPEND_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_WIDTH = 15;
    // frame layout
    localparam int BITS_PER_BYTE = 8;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam int ADDR_WIDTH = 7;
    localparam int DATA_WIDTH = 8;
    localparam int LEN_WIDTH = 8;
    // dummy read target that gives chip select its first rising edge
    localparam logic [6:0] ADDR_PROBE = 7'h7f;
    // device registers that hold the interface selections
    localparam logic [6:0] ADDR_NONVOLATILE_CONFIG = 7'h70;
    localparam logic [6:0] ADDR_INTERFACE_CONFIG = 7'h6b;
    // input synchroniser depth
    localparam int SYNC_STAGES = 3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_LOW = 3'b011,
        ST_HIGH = 3'b010,
        ST_TAIL = 3'b110,
        ST_GAP = 3'b111
    } host_state_t;
endpackage

// [sck_half_timer.sv]
// half-period enable divider for the serial clock
`timescale 1ns/1ps
module sck_half_timer #(
    parameter int HALF_CYCLES = spi_host_pkg::SCK_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic run,
    output logic tick
);
    localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (!run || count_reg == LAST) begin
            count_next = '0;
        end else begin
            count_next = count_reg + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign tick = run && (count_reg == LAST);
endmodule

// [spi_host_port.sv]
// serial host that drives the sensor's chip select, clock and data pins
`timescale 1ns/1ps
module spi_host_port #(
    parameter int HALF_CYCLES = spi_host_pkg::SCK_HALF_CYCLES,
    parameter int IDLE_NORMAL_CYCLES = spi_host_pkg::IDLE_NORMAL_CYCLES,
    parameter int IDLE_SUSPEND_CYCLES = spi_host_pkg::IDLE_SUSPEND_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqRead,
    input wire logic [spi_host_pkg::ADDR_WIDTH-1:0] reqAddr,
    input wire logic [spi_host_pkg::LEN_WIDTH-1:0] reqLen,
    input wire logic [spi_host_pkg::DATA_WIDTH-1:0] wrData,
    output logic wrTake,
    output logic [spi_host_pkg::DATA_WIDTH-1:0] rdData,
    output logic rdValid,
    output logic busy,
    output logic probeDone,
    input wire logic threeWire,
    input wire logic suspendMode,
    input wire logic clockMode11,
    output logic chipSelectLow,
    output logic sck,
    output logic serialDataInO,
    output logic serialDataInOe,
    input wire logic serialDataInI,
    input wire logic serialDataOut
);
    localparam int GW = spi_host_pkg::GAP_WIDTH;
    localparam int DW = spi_host_pkg::DATA_WIDTH;
    localparam int LW = spi_host_pkg::LEN_WIDTH;
    localparam logic [GW-1:0] GAP_NORMAL = GW'(IDLE_NORMAL_CYCLES);
    localparam logic [GW-1:0] GAP_SUSPEND = GW'(IDLE_SUSPEND_CYCLES);
    localparam logic [GW-1:0] GAP_READ = GW'(HALF_CYCLES);
    localparam logic [2:0] LAST_BIT = 3'(spi_host_pkg::BITS_PER_BYTE - 1);

    // three-stage synchronisers for the two device-driven data lines
    logic [1:0] pinIn;
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] sync3_reg;
    logic [1:0] stable_reg;
    logic [1:0] stable_next;

    assign pinIn = {serialDataInI, serialDataOut};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gSync
            always_comb begin
                stable_next[g] = stable_reg[g];
                if (sync2_reg[g] == sync3_reg[g]) begin
                    stable_next[g] = sync3_reg[g];
                end
            end
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    sync1_reg[g] <= 1'b0;
                    sync2_reg[g] <= 1'b0;
                    sync3_reg[g] <= 1'b0;
                    stable_reg[g] <= 1'b0;
                end else begin
                    sync1_reg[g] <= pinIn[g];
                    sync2_reg[g] <= sync1_reg[g];
                    sync3_reg[g] <= sync2_reg[g];
                    stable_reg[g] <= stable_next[g];
                end
            end
        end
    endgenerate

    // frame sequencer state
    spi_host_pkg::host_state_t state_reg;
    spi_host_pkg::host_state_t state_next;
    logic tick;
    logic run;
    logic [2:0] bitCnt_reg;
    logic [2:0] bitCnt_next;
    logic [LW-1:0] bytesLeft_reg;
    logic [LW-1:0] bytesLeft_next;
    logic inHeader_reg;
    logic inHeader_next;
    logic isRead_reg;
    logic isRead_next;
    logic isProbe_reg;
    logic isProbe_next;
    logic mode11_reg;
    logic mode11_next;
    logic wire3_reg;
    logic wire3_next;
    logic [DW-1:0] txShift_reg;
    logic [DW-1:0] txShift_next;
    logic [DW-1:0] rxShift_reg;
    logic [DW-1:0] rxShift_next;
    logic dataOut_reg;
    logic dataOut_next;
    logic sck_reg;
    logic sck_next;
    logic csLow_reg;
    logic csLow_next;
    logic [GW-1:0] gap_reg;
    logic [GW-1:0] gap_next;
    logic probePending_reg;
    logic probePending_next;
    logic [DW-1:0] rdData_reg;
    logic [DW-1:0] rdData_next;
    logic rdValid_reg;
    logic rdValid_next;
    logic wrTake_reg;
    logic wrTake_next;
    logic idleMode11;
    logic rxBit;
    logic [DW-1:0] rxByte;

    // three-wire framing forces mode 11 so chip select moves with the clock high
    assign idleMode11 = clockMode11 | threeWire;
    assign run = (state_reg != spi_host_pkg::ST_IDLE) && (state_reg != spi_host_pkg::ST_GAP);
    assign rxBit = wire3_reg ? stable_reg[1] : stable_reg[0];
    assign rxByte = {rxShift_reg[DW-2:0], rxBit};

    sck_half_timer #(
        .HALF_CYCLES(HALF_CYCLES)
    ) uHalf (
        .clk(clk),
        .rstn(rstn),
        .run(run),
        .tick(tick)
    );

    always_comb begin
        state_next = state_reg;
        bitCnt_next = bitCnt_reg;
        bytesLeft_next = bytesLeft_reg;
        inHeader_next = inHeader_reg;
        isRead_next = isRead_reg;
        isProbe_next = isProbe_reg;
        mode11_next = mode11_reg;
        wire3_next = wire3_reg;
        txShift_next = txShift_reg;
        rxShift_next = rxShift_reg;
        dataOut_next = dataOut_reg;
        sck_next = sck_reg;
        csLow_next = csLow_reg;
        gap_next = gap_reg;
        probePending_next = probePending_reg;
        rdData_next = rdData_reg;
        rdValid_next = 1'b0;
        wrTake_next = 1'b0;
        unique case (state_reg)
            spi_host_pkg::ST_IDLE: begin
                sck_next = idleMode11;
                if (probePending_reg || reqValid) begin
                    // dummy single read gives the port its first chip select rise
                    isProbe_next = probePending_reg;
                    isRead_next = probePending_reg ? spi_host_pkg::DIR_READ : reqRead;
                    txShift_next = probePending_reg ? {spi_host_pkg::DIR_READ, spi_host_pkg::ADDR_PROBE}
                        : {reqRead, reqAddr};
                    bytesLeft_next = (probePending_reg || reqLen == '0) ? LW'(1) : reqLen;
                    mode11_next = idleMode11;
                    wire3_next = threeWire;
                    inHeader_next = 1'b1;
                    bitCnt_next = '0;
                    csLow_next = 1'b1;
                    state_next = spi_host_pkg::ST_SETUP;
                end
            end
            spi_host_pkg::ST_SETUP: begin
                if (tick) begin
                    state_next = spi_host_pkg::ST_LOW;
                    sck_next = 1'b0;
                    dataOut_next = txShift_reg[DW-1];
                    txShift_next = {txShift_reg[DW-2:0], 1'b0};
                end
            end
            spi_host_pkg::ST_LOW: begin
                if (tick) begin
                    state_next = spi_host_pkg::ST_HIGH;
                    sck_next = 1'b1;
                end
            end
            spi_host_pkg::ST_HIGH: begin
                if (tick) begin
                    // sample late in the high phase to cover output delay and synchroniser
                    rxShift_next = rxByte;
                    bitCnt_next = bitCnt_reg + 3'(1);
                    state_next = spi_host_pkg::ST_LOW;
                    sck_next = 1'b0;
                    dataOut_next = txShift_reg[DW-1];
                    txShift_next = {txShift_reg[DW-2:0], 1'b0};
                    if (bitCnt_reg == LAST_BIT) begin
                        if (inHeader_reg) begin
                            inHeader_next = 1'b0;
                            if (!isRead_reg) begin
                                dataOut_next = wrData[DW-1];
                                txShift_next = {wrData[DW-2:0], 1'b0};
                                wrTake_next = 1'b1;
                            end
                        end else begin
                            bytesLeft_next = bytesLeft_reg - LW'(1);
                            if (isRead_reg && !isProbe_reg) begin
                                rdData_next = rxByte;
                                rdValid_next = 1'b1;
                            end
                            if (bytesLeft_reg == LW'(1)) begin
                                state_next = spi_host_pkg::ST_TAIL;
                                sck_next = mode11_reg;
                            end else if (!isRead_reg) begin
                                // device steps the address, so the next byte simply follows
                                dataOut_next = wrData[DW-1];
                                txShift_next = {wrData[DW-2:0], 1'b0};
                                wrTake_next = 1'b1;
                            end
                            // reads continue with chip select low for the next address
                        end
                    end
                end
            end
            spi_host_pkg::ST_TAIL: begin
                if (tick) begin
                    csLow_next = 1'b0;
                    probePending_next = 1'b0;
                    state_next = spi_host_pkg::ST_GAP;
                    if (isRead_reg) begin
                        gap_next = GAP_READ;
                    end else if (suspendMode) begin
                        gap_next = GAP_SUSPEND;
                    end else begin
                        gap_next = GAP_NORMAL;
                    end
                end
            end
            spi_host_pkg::ST_GAP: begin
                sck_next = idleMode11;
                if (gap_reg <= GW'(1)) begin
                    state_next = spi_host_pkg::ST_IDLE;
                end else begin
                    gap_next = gap_reg - GW'(1);
                end
            end
            default: begin
                state_next = spi_host_pkg::ST_IDLE;
                csLow_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= spi_host_pkg::ST_IDLE;
            bitCnt_reg <= '0;
            bytesLeft_reg <= '0;
            inHeader_reg <= 1'b0;
            isRead_reg <= 1'b0;
            isProbe_reg <= 1'b0;
            mode11_reg <= 1'b0;
            wire3_reg <= 1'b0;
            txShift_reg <= '0;
            rxShift_reg <= '0;
            dataOut_reg <= 1'b0;
            sck_reg <= 1'b0;
            csLow_reg <= 1'b0;
            gap_reg <= '0;
            probePending_reg <= 1'b1;
            rdData_reg <= '0;
            rdValid_reg <= 1'b0;
            wrTake_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            bitCnt_reg <= bitCnt_next;
            bytesLeft_reg <= bytesLeft_next;
            inHeader_reg <= inHeader_next;
            isRead_reg <= isRead_next;
            isProbe_reg <= isProbe_next;
            mode11_reg <= mode11_next;
            wire3_reg <= wire3_next;
            txShift_reg <= txShift_next;
            rxShift_reg <= rxShift_next;
            dataOut_reg <= dataOut_next;
            sck_reg <= sck_next;
            csLow_reg <= csLow_next;
            gap_reg <= gap_next;
            probePending_reg <= probePending_next;
            rdData_reg <= rdData_next;
            rdValid_reg <= rdValid_next;
            wrTake_reg <= wrTake_next;
        end
    end

    // chip select pin is active low; reset leaves it high
    assign chipSelectLow = !csLow_reg;
    assign sck = sck_reg;
    assign serialDataInO = dataOut_reg;
    // three-wire: release the shared pin while the device returns read data
    assign serialDataInOe = wire3_reg ? (csLow_reg && !(isRead_reg && !inHeader_reg)) : 1'b1;
    assign reqReady = (state_reg == spi_host_pkg::ST_IDLE) && !probePending_reg;
    assign busy = (state_reg != spi_host_pkg::ST_IDLE);
    assign probeDone = !probePending_reg;
    assign rdData = rdData_reg;
    assign rdValid = rdValid_reg;
    assign wrTake = wrTake_reg;
endmodule

// [spi_host_port_checker.sv]
// assertions on the serial host port pins and request handshake
`timescale 1ns/1ps
module spi_host_port_checker #(
    parameter int HALF_CYCLES = 6,
    parameter int IDLE_NORMAL_CYCLES = 100,
    parameter int IDLE_SUSPEND_CYCLES = 22500
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic reqRead,
    input wire logic [7:0] reqLen,
    input wire logic busy,
    input wire logic probeDone,
    input wire logic threeWire,
    input wire logic suspendMode,
    input wire logic clockMode11,
    input wire logic chipSelectLow,
    input wire logic sck,
    input wire logic serialDataInO,
    input wire logic serialDataInOe
);
    logic curRd, curW3, curM11;
    logic [8:0] curLen;
    logic [11:0] rises;
    logic [15:0] highCnt, needGap;
    logic idleLvl;
    // idle clock level that the current inputs ask for
    assign idleLvl = clockMode11 | threeWire;
    // frame attributes latched at the take, counts of clock rises and idle time
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            curRd <= 1'b1;
            curW3 <= 1'b0;
            curM11 <= 1'b0;
            curLen <= 9'h001;
            rises <= 12'h000;
            highCnt <= 16'h0000;
            needGap <= 16'h0000;
        end else begin
            highCnt <= chipSelectLow ? highCnt + 16'(highCnt != 16'hffff) : 16'h0000;
            if (reqValid && reqReady) begin
                curRd <= reqRead;
                curW3 <= threeWire;
                curM11 <= clockMode11 | threeWire;
                curLen <= (reqLen == 8'h00) ? 9'h001 : {1'b0, reqLen};
                rises <= 12'h000;
            end else if (!chipSelectLow && !$past(chipSelectLow) && $rose(sck)) begin
                rises <= rises + 12'h001;
            end
            if ($rose(chipSelectLow)) begin
                needGap <= curRd ? 16'(HALF_CYCLES) : suspendMode ? 16'(IDLE_SUSPEND_CYCLES) : 16'(IDLE_NORMAL_CYCLES);
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_ready_idle: assert property (reqReady |-> !busy && probeDone) else $error("ready while busy");
    a_take_select: assert property (reqValid && reqReady |=> !chipSelectLow && busy) else $error("no select");
    a_clock_still: assert property (chipSelectLow && $past(chipSelectLow) && $past(rstn)
        |-> sck == $past(idleLvl)) else $error("clock moved while deselected");
    a_data_hold: assert property (!chipSelectLow && $rose(sck) |-> $stable(serialDataInO))
        else $error("data moved");
    a_mode_select: assert property ($fell(chipSelectLow) |-> sck == curM11) else $error("wrong idle level");
    a_frame_bits: assert property ($rose(chipSelectLow) |-> rises == 12'(8 + 8 * curLen))
        else $error("bit count");
    a_post_gap: assert property ($fell(chipSelectLow) |-> highCnt >= needGap) else $error("gap too short");
    a_three_cs: assert property ($changed(chipSelectLow) && curW3 |-> sck && $past(sck))
        else $error("cs with sck low");
    a_oe_three: assert property (curW3 && chipSelectLow |-> !serialDataInOe) else $error("drives idle line");
    a_oe_four: assert property (!curW3 |-> serialDataInOe) else $error("released data line");
endmodule
bind spi_host_port spi_host_port_checker #(.HALF_CYCLES(HALF_CYCLES)) checker_i (.clk(clk), .rstn(rstn),
    .reqValid(reqValid),
    .reqReady(reqReady), .reqRead(reqRead), .reqLen(reqLen), .busy(busy), .probeDone(probeDone),
    .threeWire(threeWire), .suspendMode(suspendMode), .clockMode11(clockMode11), .chipSelectLow(chipSelectLow),
    .sck(sck), .serialDataInO(serialDataInO), .serialDataInOe(serialDataInOe));

// [sensor_port_model.sv]
// behavioural model of the sensor's serial register port
`timescale 1ns/1ps
module sensor_port_model (
    input wire logic rstn,
    input wire logic chipSelectLow,
    input wire logic sck,
    input wire logic sdioWire,
    output logic sdioO,
    output logic sdioOe,
    output logic serialDataOut
);
    logic [7:0] regs [128];
    logic [7:0] sh = 8'h00, probeHdr = 8'h00;
    logic [6:0] ptr = 7'h00;
    logic spiOn = 1'b0, rd = 1'b0, drv = 1'b0, last = 1'b0;
    int cnt = 0;
    wire threeW = regs[7'h6b][0];
    initial begin
        for (int i = 0; i < 128; i++) regs[i] = 8'(i) ^ 8'h5a;
        regs[7'h70] = 8'h00;
        regs[7'h6b] = 8'h00;
    end
    always @(negedge rstn) begin
        spiOn = regs[7'h70][0] === 1'b1;
        regs[7'h6b] = 8'h00;
    end
    always @(posedge chipSelectLow) begin
        if (rstn === 1'b1) spiOn = 1'b1;
        drv = 1'b0;
    end
    // both modes sample on the rising edge, so the idle level needs no state
    always @(negedge chipSelectLow) cnt = 0;
    always @(posedge sck) begin
        if (!chipSelectLow) begin
            sh = {sh[6:0], sdioWire};
            cnt++;
            if (cnt == 8) begin
                rd = sh[7];
                ptr = sh[6:0];
                if (!spiOn) probeHdr = sh;
            end else if (cnt > 8 && cnt % 8 == 0 && spiOn) begin
                if (!rd) regs[ptr] = sh;
                ptr++;
            end
        end
    end
    always @(negedge sck) begin
        if (!chipSelectLow && spiOn && rd && cnt >= 8) begin
            drv = 1'b1;
            last = regs[ptr][7 - cnt % 8];
        end
    end
    // released lines show the inverse of the last bit, never a held value
    assign sdioOe = drv && threeW;
    assign sdioO = drv ? last : !last;
    assign serialDataOut = (drv && !threeW) ? last : !last;
endmodule

// [spi_host_port_tb.sv]
// self-checking bench for the serial host port with a sensor model
`timescale 1ns/1ps
module spi_host_port_tb;
    logic clk = 1'b0, rstn = 1'b0, reqValid = 1'b0, reqRead = 1'b0;
    logic threeWire = 1'b0, suspendMode = 1'b0, clockMode11 = 1'b0;
    logic [6:0] reqAddr = 7'h00;
    logic [7:0] reqLen = 8'h01, wrData = 8'h00, rdData;
    logic reqReady, wrTake, rdValid, busy, probeDone, chipSelectLow, sck, hostO, hostOe, devO, devOe, devSdo;
    logic sdioWire;
    logic [7:0] put [8];
    logic [7:0] got [8];
    int error_cnt = 0, n_tests = 0;
    always #10 clk = ~clk;
    assign sdioWire = hostOe ? hostO : devOe ? devO : !hostO;
    spi_host_port #(.HALF_CYCLES(6)) dut (
        .clk(clk), .rstn(rstn), .reqValid(reqValid), .reqReady(reqReady), .reqRead(reqRead),
        .reqAddr(reqAddr), .reqLen(reqLen), .wrData(wrData), .wrTake(wrTake), .rdData(rdData),
        .rdValid(rdValid), .busy(busy), .probeDone(probeDone), .threeWire(threeWire),
        .suspendMode(suspendMode), .clockMode11(clockMode11), .chipSelectLow(chipSelectLow), .sck(sck),
        .serialDataInO(hostO), .serialDataInOe(hostOe), .serialDataInI(sdioWire), .serialDataOut(devSdo));
    sensor_port_model dev (.rstn(rstn), .chipSelectLow(chipSelectLow), .sck(sck), .sdioWire(sdioWire),
        .sdioO(devO), .sdioOe(devOe), .serialDataOut(devSdo));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic timeout(input string what);
        error_cnt++;
        $display("BAD %s expected done seen timeout", what);
        stop_test();
    endtask
    task automatic wait_probe();
        int k;
        for (k = 0; k < 3000 && probeDone !== 1'b1; k++) @(negedge clk);
        if (k == 3000) timeout("probe");
    endtask
    // one frame: write bytes come from put, read bytes land in got
    task automatic xfer(input logic rd, input logic [6:0] addr, input int len);
        int i, k;
        i = 0;
        @(posedge clk);
        reqValid <= 1'b1;
        reqRead <= rd;
        reqAddr <= addr;
        reqLen <= 8'(len);
        wrData <= put[0];
        @(negedge clk);
        for (k = 0; k < 30000 && reqReady !== 1'b1; k++) @(negedge clk);
        if (k == 30000) timeout("request");
        @(posedge clk);
        reqValid <= 1'b0;
        for (k = 0; k < 30000 && !(i == len && busy === 1'b0); k++) begin
            @(negedge clk);
            if (wrTake === 1'b1 || rdValid === 1'b1) begin
                got[i % 8] = rdData;
                i++;
                @(posedge clk);
                wrData <= put[i % 8];
            end
        end
        if (k == 30000) timeout("frame");
        chk("byte count", 8'(i), 8'(len));
    endtask
    task automatic sc_startup();
        repeat (10) @(posedge clk);
        chk("cs in reset", {7'h00, chipSelectLow}, 8'h01);
        chk("two-wire at reset", {7'h00, dev.spiOn}, 8'h00);
        rstn <= 1'b1;
        wait_probe();
        chk("probe header", dev.probeHdr, 8'hff);
        chk("serial after probe", {7'h00, dev.spiOn}, 8'h01);
    endtask
    // mode 00 in normal power, then mode 11 in suspend
    task automatic sc_modes();
        for (int m = 0; m < 2; m++) begin
            @(posedge clk);
            clockMode11 <= m[0];
            suspendMode <= m[0];
            put[0] = 8'ha5 ^ 8'(m);
            xfer(1'b0, 7'h12, 1);
            chk("single write", dev.regs[7'h12], 8'ha5 ^ 8'(m));
            xfer(1'b1, 7'h12, 1);
            chk("single read", got[0], 8'ha5 ^ 8'(m));
            for (int j = 0; j < 3; j++) put[j] = 8'h30 + 8'(j * 17 + m);
            xfer(1'b0, 7'h40, 3);
            xfer(1'b1, 7'h40, 4);
            for (int j = 0; j < 3; j++) chk("burst", got[j], 8'h30 + 8'(j * 17 + m));
            chk("burst tail", got[3], 8'h43 ^ 8'h5a);
        end
        @(posedge clk);
        clockMode11 <= 1'b0;
        suspendMode <= 1'b0;
    endtask
    task automatic sc_nonvolatile();
        put[0] = 8'h01;
        xfer(1'b0, 7'h70, 1);
        @(posedge clk);
        rstn <= 1'b0;
        @(negedge clk);
        chk("nonvolatile select", {7'h00, dev.spiOn}, 8'h01);
        @(posedge clk);
        rstn <= 1'b1;
        wait_probe();
    endtask
    task automatic sc_three();
        put[0] = 8'h01;
        xfer(1'b0, 7'h6b, 1);
        chk("three-wire on", {7'h00, dev.threeW}, 8'h01);
        @(posedge clk);
        threeWire <= 1'b1;
        put[0] = 8'hc3;
        xfer(1'b0, 7'h60, 1);
        xfer(1'b1, 7'h60, 2);
        chk("three-wire read", got[0], 8'hc3);
        chk("three-wire burst", got[1], 8'h61 ^ 8'h5a);
    endtask
    initial begin
        sc_startup();
        sc_modes();
        sc_nonvolatile();
        sc_three();
        stop_test();
    end
endmodule
